/* msd_pkg.sv */
// Shared constants and types for the memory space decoder.
// Assumes one core clock and an active low asynchronous reset.

`default_nettype none

package msd_pkg;

  // --------------------------------------------------------------
  // Internal space layout
  // --------------------------------------------------------------
  localparam int unsigned IRAM_DEPTH  = 256;
  localparam int unsigned FREG_DEPTH  = 128;
  localparam logic [7:0]  BANK_TOP    = 8'h1f;
  localparam logic [7:0]  BIT_BASE    = 8'h20;
  localparam logic [7:0]  BIT_TOP     = 8'h2f;
  localparam logic [7:0]  UPPER_BASE  = 8'h80;
  localparam logic [7:0]  PSW_ADDR    = 8'hd0;
  localparam logic [7:0]  DP0_LO_ADDR = 8'h82;
  localparam logic [7:0]  DP0_HI_ADDR = 8'h83;
  localparam logic [7:0]  DP1_LO_ADDR = 8'h84;
  localparam logic [7:0]  DP1_HI_ADDR = 8'h85;
  localparam int unsigned PSW_BANK_LSB = 3;
  localparam logic [1:0]  BANK_RST    = 2'h0;

  // --------------------------------------------------------------
  // Program space vectors
  // --------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE  = 16'h0003;
  localparam logic [15:0] VECTOR_STEP  = 16'h0008;

  // --------------------------------------------------------------
  // Placement control bits and value held during reset
  // --------------------------------------------------------------
  localparam int unsigned PL_WIDTH     = 5;
  localparam int unsigned PL_MAIN_PROG = 0;
  localparam int unsigned PL_MAIN_DATA = 1;
  localparam int unsigned PL_SEC_PROG  = 2;
  localparam int unsigned PL_SEC_DATA  = 3;
  localparam int unsigned PL_SRAM_PROG = 4;
  localparam logic [4:0]  PL_RST       = 5'h09;

  // Access kinds issued by the core
  typedef enum logic [2:0] {
    MSD_OP_DIRECT, MSD_OP_INDIRECT, MSD_OP_REG, MSD_OP_BIT,
    MSD_OP_FETCH, MSD_OP_EXTERNAL_DATA_SPACE, MSD_OP_JUMP, MSD_OP_VECTOR
  } msd_op_t;

  typedef enum logic [1:0] {MSD_ST_IDLE, MSD_ST_INT, MSD_ST_EXT} msd_st_t;

endpackage

`default_nettype wire

/* msd_mem_if.sv */
// Byte memory port between the decoder and its storage arrays.
// Assumes storage with registered read data, one cycle latency.

`default_nettype none

interface msd_mem_if #(parameter int unsigned AW = 8);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface

`default_nettype wire

/* msd_byte_ram.sv */
// Single port byte storage with registered read data.
// Assumes the caller holds the address for the cycle after a read.

`default_nettype none

module msd_byte_ram
  import msd_pkg::*;
#(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  msd_mem_if.mem    port
);

  logic [7:0] mem [DEPTH];
  logic [7:0] rd_r;

  // Array itself carries no reset, as in real SRAM
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  // Read before write, so a merge sees the old byte
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= mem[port.addr];
    end
  end

  assign port.rdata = rd_r;

endmodule

`default_nettype wire

/* msd_space_decoder.sv */
// Memory space decoder between the 8-bit core and its memories.
// Assumes on-chip external memories answer in the strobe cycle,
// and that placement settings come from logic on core_clk.

`default_nettype none

module msd_space_decoder
  import msd_pkg::*;
#(
  parameter logic [15:0] MAIN_BASE = 16'h0000,
  parameter logic [15:0] MAIN_TOP  = 16'h7fff,
  parameter logic [15:0] SEC_BASE  = 16'h8000,
  parameter logic [15:0] SEC_TOP   = 16'h9fff,
  parameter logic [15:0] SRAM_BASE = 16'ha000,
  parameter logic [15:0] SRAM_TOP  = 16'hbfff,
  parameter logic [15:0] CRB_BASE  = 16'hff00,
  parameter logic [15:0] CRB_TOP   = 16'hffff
) (
  input  wire logic          core_clk,
  input  wire logic          resetn,
  input  wire logic          acc_valid,
  input  wire msd_op_t       acc_op,
  input  wire logic          acc_write,
  input  wire logic [15:0]   acc_addr,
  input  wire logic [7:0]    acc_wdata,
  input  wire logic          acc_ptr_sel,
  output logic               acc_ready,
  output logic               acc_done,
  output logic [7:0]         acc_rdata,
  output logic [15:0]        program_counter,
  output logic [1:0]         active_bank,
  input  wire logic [4:0]    nv_placement,
  input  wire logic          placement_ovr_valid,
  input  wire logic [4:0]    placement_ovr_value,
  output logic [4:0]         memory_placement_control,
  output logic [15:0]        ext_addr,
  output logic [7:0]         ext_wdata,
  input  wire logic [7:0]    ext_rdata,
  output logic               program_store_strobe_n,
  output logic               external_data_space_read_strobe_n,
  output logic               external_data_space_write_strobe_n,
  output logic               sel_main_flash,
  output logic               sel_sec_flash,
  output logic               sel_sram,
  output logic               sel_ctrl_block
);

  // --------------------------------------------------------------
  // Storage arrays
  // --------------------------------------------------------------
  msd_mem_if #(.AW(8)) iram ();
  msd_mem_if #(.AW(7)) freg ();

  msd_byte_ram #(.DEPTH(IRAM_DEPTH), .AW(8)) u_iram (
    .core_clk (core_clk),
    .resetn   (resetn),
    .port     (iram)
  );

  msd_byte_ram #(.DEPTH(FREG_DEPTH), .AW(7)) u_freg (
    .core_clk (core_clk),
    .resetn   (resetn),
    .port     (freg)
  );

  msd_st_t     st_r;
  msd_op_t     op_r;
  logic        wr_r;
  logic        wbit_r;
  logic [2:0]  bit_r;
  logic [7:0]  tgt_r;
  logic        to_freg_r;
  logic [1:0]  bank_r;
  logic [15:0] dp0_r;
  logic [15:0] dp1_r;
  logic [15:0] pc_r;
  logic [4:0]  pl_r;
  logic        cap_pend_r;
  logic        done_r;
  logic [7:0]  rdata_r;
  logic        take;
  logic        is_int;
  logic        is_ext;
  logic [7:0]  tgt_a;
  logic        to_freg;
  logic [7:0]  cur_byte;
  logic [7:0]  merged;
  logic [15:0] ext_a_nxt;
  logic [3:0]  sel_nxt;
  logic        bit_rmw;
  logic [15:0] ext_addr_r;
  logic [7:0]  ext_wdata_r;
  logic        program_store_strobe_n_r;
  logic        rd_n_r;
  logic        wr_n_r;
  logic [3:0]  sel_r;

  // --------------------------------------------------------------
  // Request acceptance
  // --------------------------------------------------------------
  assign acc_ready = (st_r == MSD_ST_IDLE);
  assign take      = acc_valid && acc_ready;
  assign is_int    = acc_op inside {MSD_OP_DIRECT, MSD_OP_INDIRECT,
                                    MSD_OP_REG, MSD_OP_BIT};
  assign is_ext    = acc_op inside {MSD_OP_FETCH, MSD_OP_EXTERNAL_DATA_SPACE};

  // Internal target byte and which array holds it
  always_comb begin
    tgt_a   = acc_addr[7:0];
    to_freg = 1'b0;
    case (acc_op)
      // low half is plain RAM for direct
      // upper direct goes to function registers
      MSD_OP_DIRECT: to_freg = acc_addr[7];
      MSD_OP_INDIRECT: to_freg = 1'b0;
      MSD_OP_REG: tgt_a = {3'h0, bank_r, acc_addr[2:0]};
      MSD_OP_BIT: begin
        to_freg = acc_addr[7];
        // function register bits at x0 or x8
        // bits live in bytes 0x20 to 0x2f
        tgt_a   = acc_addr[7] ? {acc_addr[7:3], 3'h0}
                              : BIT_BASE + {4'h0, acc_addr[6:3]};
      end
      default: tgt_a = acc_addr[7:0];
    endcase
  end

  // Bit writes read the byte first, then write the merged value
  assign cur_byte = to_freg_r ? freg.rdata : iram.rdata;
  always_comb begin
    merged         = cur_byte;
    merged[bit_r]  = wbit_r;
  end
  assign bit_rmw = (st_r == MSD_ST_INT) && (op_r == MSD_OP_BIT) && wr_r;

  // --------------------------------------------------------------
  // Array ports
  // --------------------------------------------------------------
  assign iram.addr  = acc_ready ? tgt_a : tgt_r;
  assign freg.addr  = acc_ready ? tgt_a[6:0] : tgt_r[6:0];
  assign iram.wdata = acc_ready ? acc_wdata : merged;
  assign freg.wdata = acc_ready ? acc_wdata : merged;
  assign iram.we = (take && is_int && acc_write && !to_freg &&
                    acc_op != MSD_OP_BIT) || (bit_rmw && !to_freg_r);
  assign freg.we = (take && is_int && acc_write && to_freg &&
                    acc_op != MSD_OP_BIT) || (bit_rmw && to_freg_r);

  // Latch the request for the second cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_r      <= MSD_OP_DIRECT;
      wr_r      <= 1'b0;
      wbit_r    <= 1'b0;
      bit_r     <= 3'h0;
      tgt_r     <= 8'h00;
      to_freg_r <= 1'b0;
    end else if (take) begin
      op_r      <= acc_op;
      wr_r      <= acc_write;
      wbit_r    <= acc_wdata[0];
      bit_r     <= acc_addr[2:0];
      tgt_r     <= tgt_a;
      to_freg_r <= to_freg;
    end
  end

  // --------------------------------------------------------------
  // Shadowed function registers
  // --------------------------------------------------------------
  // Watch the array write port so bit writes update shadows too
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bank_r <= BANK_RST;
      dp0_r  <= 16'h0000;
      dp1_r  <= 16'h0000;
    end else if (freg.we) begin
      case ({1'b1, freg.addr})
        // status word bits pick the bank
        PSW_ADDR:    bank_r <= freg.wdata[PSW_BANK_LSB +: 2];
        DP0_LO_ADDR: dp0_r[7:0]  <= freg.wdata;
        DP0_HI_ADDR: dp0_r[15:8] <= freg.wdata;
        DP1_LO_ADDR: dp1_r[7:0]  <= freg.wdata;
        DP1_HI_ADDR: dp1_r[15:8] <= freg.wdata;
        default:     bank_r <= bank_r;
      endcase
    end
  end
  assign active_bank = bank_r;

  // --------------------------------------------------------------
  // Program counter
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= RESET_VECTOR;
    end else if (take) begin
      case (acc_op)
        // full 16-bit wrap across program space
        MSD_OP_FETCH: pc_r <= pc_r + 16'h0001;
        MSD_OP_JUMP:  pc_r <= acc_addr;
        MSD_OP_VECTOR:
          pc_r <= VECTOR_BASE + VECTOR_STEP * {13'h0, acc_addr[2:0]};
        default: pc_r <= pc_r;
      endcase
    end
  end
  assign program_counter = pc_r;

  // --------------------------------------------------------------
  // Placement control
  // --------------------------------------------------------------
  // Captured after release; a strap cannot load under async reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pl_r       <= PL_RST;
      cap_pend_r <= 1'b1;
    end else if (cap_pend_r) begin
      pl_r       <= nv_placement;
      cap_pend_r <= 1'b0;
    end else if (placement_ovr_valid) begin
      // remap flash to data space for updates
      pl_r <= placement_ovr_value;
    end
  end
  assign memory_placement_control = pl_r;

  // Region decode for one space; bits are main, sec, sram, block
  function automatic logic [3:0] decode(input logic [15:0] a,
                                        input logic        prog,
                                        input logic [4:0]  pl);
    logic [3:0] s;
    s = 4'h0;
    s[0] = (a >= MAIN_BASE) && (a <= MAIN_TOP) &&
           (prog ? pl[PL_MAIN_PROG] : pl[PL_MAIN_DATA]);
    s[1] = (a >= SEC_BASE) && (a <= SEC_TOP) &&
           (prog ? pl[PL_SEC_PROG] : pl[PL_SEC_DATA]);
    // SRAM always data, block data only
    s[2] = (a >= SRAM_BASE) && (a <= SRAM_TOP) &&
           (!prog || pl[PL_SRAM_PROG]);
    s[3] = (a >= CRB_BASE) && (a <= CRB_TOP) && !prog;
    return s;
  endfunction

  // pointer select picks source or destination
  assign ext_a_nxt = (acc_op == MSD_OP_FETCH) ? pc_r
                   : (acc_ptr_sel ? dp1_r : dp0_r);
  assign sel_nxt   = decode(ext_a_nxt, acc_op == MSD_OP_FETCH, pl_r);

  // --------------------------------------------------------------
  // External bus strobes
  // --------------------------------------------------------------
  // Strobes stand for one cycle; address and data hold afterwards
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ext_addr_r  <= 16'h0000;
      ext_wdata_r <= 8'h00;
      program_store_strobe_n_r    <= 1'b1;
      rd_n_r      <= 1'b1;
      wr_n_r      <= 1'b1;
      sel_r       <= 4'h0;
    end else if (take && is_ext) begin
      ext_addr_r  <= ext_a_nxt;
      ext_wdata_r <= acc_wdata;
      program_store_strobe_n_r    <= (acc_op != MSD_OP_FETCH);
      rd_n_r      <= !(acc_op == MSD_OP_EXTERNAL_DATA_SPACE && !acc_write);
      wr_n_r      <= !(acc_op == MSD_OP_EXTERNAL_DATA_SPACE && acc_write);
      sel_r       <= sel_nxt;
    end else begin
      program_store_strobe_n_r <= 1'b1;
      rd_n_r   <= 1'b1;
      wr_n_r   <= 1'b1;
      sel_r    <= 4'h0;
    end
  end
  assign ext_addr               = ext_addr_r;
  assign ext_wdata              = ext_wdata_r;
  assign program_store_strobe_n = program_store_strobe_n_r;
  assign external_data_space_read_strobe_n    = rd_n_r;
  assign external_data_space_write_strobe_n   = wr_n_r;
  assign sel_main_flash         = sel_r[0];
  assign sel_sec_flash          = sel_r[1];
  assign sel_sram               = sel_r[2];
  assign sel_ctrl_block         = sel_r[3];

  // --------------------------------------------------------------
  // Sequencer and answer
  // --------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MSD_ST_IDLE;
    end else begin
      case (st_r)
        MSD_ST_IDLE: begin
          if (take && is_int) begin
            st_r <= MSD_ST_INT;
          end else if (take && is_ext) begin
            st_r <= MSD_ST_EXT;
          end
        end
        default: st_r <= MSD_ST_IDLE;
      endcase
    end
  end

  // Answer one cycle after the data phase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      done_r <= (st_r != MSD_ST_IDLE) || (take &&
                (acc_op inside {MSD_OP_JUMP, MSD_OP_VECTOR}));
      if (st_r == MSD_ST_INT) begin
        // single bit answers in bit zero
        rdata_r <= (op_r == MSD_OP_BIT) ? {7'h00, cur_byte[bit_r]}
                                        : cur_byte;
      end else if (st_r == MSD_ST_EXT) begin
        rdata_r <= ext_rdata;
      end
    end
  end
  assign acc_done  = done_r;
  assign acc_rdata = rdata_r;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_bus_idle;
    program_store_strobe_n && external_data_space_read_strobe_n && external_data_space_write_strobe_n;
  endsequence
  // Answer lands in the cycle after the strobe, with the bus idle
  sequence s_answer;
    s_bus_idle ##0 acc_done;
  endsequence

  low_direct_a: assert property (
    take && acc_op == MSD_OP_DIRECT && !acc_addr[7]
    |-> !to_freg ##1 (st_r == MSD_ST_INT) ##1 acc_done)
    else $error("low direct access left internal RAM");
  bank_pick_a: assert property (
    take && acc_op == MSD_OP_REG
    |-> iram.addr == {3'h0, active_bank, acc_addr[2:0]})
    else $error("register access missed active bank");
  bit_area_a: assert property (
    take && acc_op == MSD_OP_BIT && !acc_addr[7]
    |-> iram.addr >= BIT_BASE && iram.addr <= BIT_TOP)
    else $error("bit access outside bit area");
  upper_ind_a: assert property (
    take && acc_op == MSD_OP_INDIRECT
    |-> !freg.we && iram.addr == acc_addr[7:0])
    else $error("indirect access reached function registers");
  freg_bit_a: assert property (
    take && acc_op == MSD_OP_BIT && acc_addr[7]
    |-> freg.addr[2:0] == 3'h0)
    else $error("function register bit byte misaligned");
  fetch_seq_a: assert property (
    take && acc_op == MSD_OP_FETCH
    |=> !program_store_strobe_n && ext_addr == $past(pc_r)
        && pc_r == $past(pc_r) + 16'h0001 ##1 s_answer)
    else $error("fetch strobe or counter wrong");
  reset_pc_a: assert property (
    $rose(resetn) |-> program_counter == RESET_VECTOR)
    else $error("counter not at reset vector");
  vector_a: assert property (
    take && acc_op == MSD_OP_VECTOR |=> program_counter ==
    VECTOR_BASE + VECTOR_STEP * {13'h0, $past(acc_addr[2:0])})
    else $error("interrupt vector address wrong");
  external_data_space_wr_a: assert property (
    take && acc_op == MSD_OP_EXTERNAL_DATA_SPACE && acc_write |=>
    !external_data_space_write_strobe_n && external_data_space_read_strobe_n &&
    ext_addr == ($past(acc_ptr_sel) ? dp1_r : dp0_r))
    else $error("data write strobe or pointer wrong");
  blk_data_a: assert property (
    !program_store_strobe_n |-> !sel_ctrl_block)
    else $error("control block selected in program space");
  no_ext_int_a: assert property (
    take && is_int |=> s_bus_idle [*2])
    else $error("internal access raised external strobe");
  no_pwrite_a: assert property (
    !external_data_space_write_strobe_n |-> program_store_strobe_n)
    else $error("write during program access");

endmodule

`default_nettype wire

/* msd_core_model.sv */
// Core side model: issues one memory access at a time to the decoder.
// Assumes acc_ready is combinational and acc_done a one-cycle pulse.
`default_nettype none

module msd_core_model
  import msd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        acc_ready,
  input  wire logic        acc_done,
  input  wire logic [7:0]  acc_rdata,
  output var  logic        acc_valid,
  output var  msd_op_t     acc_op,
  output var  logic        acc_write,
  output var  logic [15:0] acc_addr,
  output var  logic [7:0]  acc_wdata,
  output var  logic        acc_ptr_sel
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    acc_valid = 1'b0;
    acc_op = MSD_OP_DIRECT;
    acc_write = 1'b0;
    acc_addr = 16'h0000;
    acc_wdata = 8'h00;
    acc_ptr_sel = 1'b0;
  end

  // One request; held until the taking edge, then address and data scrambled so a
  // decoder that samples late sees garbage rather than a stale value
  task automatic req(input msd_op_t op, input logic w,
                     input logic [15:0] a, input logic [7:0] d,
                     input logic p, output logic [7:0] q,
                     output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 8'h00;
    while (acc_ready !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    acc_op = op;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    acc_ptr_sel = p;
    acc_valid = 1'b1;
    @(posedge core_clk);
    #1;
    acc_valid = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (acc_done === 1'b1) begin
        q = acc_rdata;
        ok = 1'b1;
      end else begin
        @(posedge core_clk);
        #1;
      end
    end
    // One-cycle answers return in the step that lowered valid; let an
    // edge pass so the next request never reassigns it in that step
    if (op inside {MSD_OP_JUMP, MSD_OP_VECTOR}) begin
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule

`default_nettype wire

/* msd_space_decoder_bench.sv */
// Testbench for the memory space decoder: core model on the request
// port, behavioural external memory on the strobe side.
// Assumes the decoder's default region bounds.
`default_nettype none

module msd_space_decoder_bench
  import msd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0] NV = 5'h15;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic acc_valid, acc_write, acc_ptr_sel, acc_ready, acc_done;
  msd_op_t acc_op;
  logic [15:0] acc_addr, program_counter, ext_addr;
  logic [7:0] acc_wdata, acc_rdata, ext_wdata, ext_rdata;
  logic [1:0] active_bank;
  logic [4:0] nv_placement = NV;
  logic placement_ovr_valid = 1'b0;
  logic [4:0] placement_ovr_value = 5'h00;
  logic [4:0] memory_placement_control;
  logic program_store_strobe_n, external_data_space_read_strobe_n, external_data_space_write_strobe_n;
  logic sel_main_flash, sel_sec_flash, sel_sram, sel_ctrl_block;
  logic [2:0] stb;
  logic [6:0] snap_r;
  logic [15:0] snap_addr;
  logic [7:0] snap_wd;
  logic [7:0] idle_pat = 8'h3c;
  int stb_cnt = 0;
  int err_count = 0;
  int checked = 0;

  always #2 core_clk = ~core_clk;

  msd_space_decoder u_dut (.core_clk, .resetn, .acc_valid, .acc_op,
    .acc_write, .acc_addr, .acc_wdata, .acc_ptr_sel, .acc_ready, .acc_done,
    .acc_rdata, .program_counter, .active_bank, .nv_placement,
    .placement_ovr_valid, .placement_ovr_value, .memory_placement_control,
    .ext_addr, .ext_wdata, .ext_rdata, .program_store_strobe_n,
    .external_data_space_read_strobe_n, .external_data_space_write_strobe_n, .sel_main_flash,
    .sel_sec_flash, .sel_sram, .sel_ctrl_block);

  msd_core_model u_core (.core_clk, .acc_ready, .acc_done, .acc_rdata,
    .acc_valid, .acc_op, .acc_write, .acc_addr, .acc_wdata, .acc_ptr_sel);

  // ------------------------------------------------------------
  // External memory: answers only in the strobe cycle, else noise
  // ------------------------------------------------------------
  assign stb = {program_store_strobe_n, external_data_space_read_strobe_n,
                external_data_space_write_strobe_n};
  assign ext_rdata = (stb !== 3'b111) ? (ext_addr[7:0] ^ 8'h5a) : idle_pat;

  // Snapshot of each strobe cycle, counted so stray pulses show up
  always @(posedge core_clk) begin
    idle_pat <= ~idle_pat;
    if (resetn === 1'b1 && stb !== 3'b111) begin
      snap_r <= {stb, sel_main_flash, sel_sec_flash, sel_sram,
                 sel_ctrl_block};
      snap_addr <= ext_addr;
      snap_wd <= ext_wdata;
      stb_cnt <= stb_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic acc(input msd_op_t op, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic p,
                     output logic [7:0] q);
    logic ok;
    u_core.req(op, w, a, d, p, q, ok);
    chk(16'(ok), 16'h0001, "access answered");
  endtask

  // Internal access: read data compared, no external strobe allowed
  task automatic iop(input msd_op_t op, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    int s;
    logic [7:0] q;
    s = stb_cnt;
    acc(op, w, a, d, 1'b0, q);
    if (!w) chk(16'(q), 16'(e), "internal read");
    chk(16'(stb_cnt - s), 16'h0000, "no ext strobe");
  endtask

  // External access: exactly one strobe, expected selects and address
  task automatic xop(input msd_op_t op, input logic w, input logic p,
                     input logic [6:0] es, input logic [15:0] ea);
    int s;
    logic [7:0] q;
    s = stb_cnt;
    acc(op, w, ea, ea[7:0] ^ 8'h77, p, q);
    chk(16'(stb_cnt - s), 16'h0001, "one strobe");
    chk(16'(snap_r), 16'(es), "strobe and select");
    chk(snap_addr, ea, "ext address");
    if (w) chk(16'(snap_wd), 16'(ea[7:0] ^ 8'h77), "ext write data");
    else chk(16'(q), 16'(ea[7:0] ^ 8'h5a), "ext read data");
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1;
    resetn = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    chk(program_counter, RESET_VECTOR, "pc in reset");
    chk(16'(active_bank), 16'(BANK_RST), "bank in reset");
    chk(16'(stb), 16'h0007, "strobes idle");
    chk(16'(acc_ready), 16'h0001, "ready in reset");
    chk(16'(acc_done), 16'h0000, "no answer in reset");
    resetn = 1'b1;
    @(posedge core_clk);
    #1;
    chk(16'(memory_placement_control), 16'(NV), "placement");
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_ram();
    iop(MSD_OP_DIRECT, 1'b1, 16'h0045, 8'ha5, 8'h00);
    iop(MSD_OP_INDIRECT, 1'b0, 16'h0045, 8'h00, 8'ha5);
    iop(MSD_OP_INDIRECT, 1'b1, 16'h0090, 8'h11, 8'h00);
    iop(MSD_OP_DIRECT, 1'b1, 16'h0090, 8'h22, 8'h00);
    iop(MSD_OP_INDIRECT, 1'b0, 16'h0090, 8'h00, 8'h11);
    iop(MSD_OP_DIRECT, 1'b0, 16'h0090, 8'h00, 8'h22);
    iop(MSD_OP_INDIRECT, 1'b1, 16'h00ff, 8'h3c, 8'h00);
    iop(MSD_OP_INDIRECT, 1'b0, 16'h00ff, 8'h00, 8'h3c);
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      iop(MSD_OP_DIRECT, 1'b1, 16'(PSW_ADDR), 8'(b << 3), 8'h00);
      chk(16'(active_bank), 16'(b), "active bank");
      iop(MSD_OP_REG, 1'b1, 16'h0005, 8'(8'h40 + b), 8'h00);
      iop(MSD_OP_DIRECT, 1'b0, 16'(b*8 + 5), 8'h00, 8'(8'h40 + b));
    end
  endtask

  task automatic t_bits();
    iop(MSD_OP_DIRECT, 1'b1, 16'h002f, 8'h00, 8'h00);
    iop(MSD_OP_BIT, 1'b1, 16'h007f, 8'h01, 8'h00);
    iop(MSD_OP_DIRECT, 1'b0, 16'h002f, 8'h00, 8'h80);
    iop(MSD_OP_BIT, 1'b0, 16'h007e, 8'h00, 8'h00);
    iop(MSD_OP_BIT, 1'b0, 16'h007f, 8'h00, 8'h01);
    iop(MSD_OP_DIRECT, 1'b1, 16'(PSW_ADDR), 8'h00, 8'h00);
    iop(MSD_OP_BIT, 1'b1, 16'h00d4, 8'h01, 8'h00);
    chk(16'(active_bank), 16'h0002, "bit set in status");
    iop(MSD_OP_BIT, 1'b1, 16'h00d4, 8'h00, 8'h00);
  endtask

  task automatic t_fetch();
    logic [7:0] q;
    xop(MSD_OP_FETCH, 1'b0, 1'b0, 7'b0111000, 16'h0000);
    chk(program_counter, 16'h0001, "pc step");
    acc(MSD_OP_JUMP, 1'b0, 16'ha000, 8'h00, 1'b0, q);
    xop(MSD_OP_FETCH, 1'b0, 1'b0, 7'b0110010, 16'ha000);
    acc(MSD_OP_JUMP, 1'b0, 16'h8000, 8'h00, 1'b0, q);
    xop(MSD_OP_FETCH, 1'b0, 1'b0, 7'b0110100, 16'h8000);
    acc(MSD_OP_JUMP, 1'b0, 16'hffff, 8'h00, 1'b0, q);
    xop(MSD_OP_FETCH, 1'b0, 1'b0, 7'b0110000, 16'hffff);
    chk(program_counter, 16'h0000, "pc wrap");
    for (int n = 0; n < 8; n++) begin
      acc(MSD_OP_VECTOR, 1'b0, 16'(n), 8'h00, 1'b0, q);
      chk(program_counter, 16'(16'h0003 + 8 * n), "vector");
    end
  endtask

  task automatic set_pl(input logic [4:0] v);
    placement_ovr_value = v;
    placement_ovr_valid = 1'b1;
    @(posedge core_clk);
    #1;
    placement_ovr_valid = 1'b0;
    chk(16'(memory_placement_control), 16'(v), "override");
  endtask

  task automatic ptr(input logic [7:0] lo_a, input logic [15:0] v);
    // only implemented function registers are addressed
    iop(MSD_OP_DIRECT, 1'b1, 16'(lo_a), v[7:0], 8'h00);
    iop(MSD_OP_DIRECT, 1'b1, 16'(lo_a + 8'h01), v[15:8], 8'h00);
  endtask

  task automatic t_external_data_space();
    logic [7:0] q;
    ptr(DP0_LO_ADDR, 16'ha010);
    ptr(DP1_LO_ADDR, 16'hff05);
    xop(MSD_OP_EXTERNAL_DATA_SPACE, 1'b1, 1'b1, 7'b1100001, 16'hff05);
    xop(MSD_OP_EXTERNAL_DATA_SPACE, 1'b0, 1'b0, 7'b1010010, 16'ha010);
    ptr(DP0_LO_ADDR, 16'h8000);
    xop(MSD_OP_EXTERNAL_DATA_SPACE, 1'b0, 1'b0, 7'b1010000, 16'h8000);
    set_pl(5'h0a);
    xop(MSD_OP_EXTERNAL_DATA_SPACE, 1'b0, 1'b0, 7'b1010100, 16'h8000);
    acc(MSD_OP_JUMP, 1'b0, 16'h8000, 8'h00, 1'b0, q);
    xop(MSD_OP_FETCH, 1'b0, 1'b0, 7'b0110000, 16'h8000);
    ptr(DP1_LO_ADDR, 16'h0100);
    xop(MSD_OP_EXTERNAL_DATA_SPACE, 1'b1, 1'b1, 7'b1101000, 16'h0100);
  endtask

  task automatic final_report();
    $display("err_count=%0d checked=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 130 cycles the run needs
  initial begin
    #100000;
    err_count++;
    final_report();
  end

  initial begin
    t_reset();
    t_ram();
    t_banks();
    t_bits();
    t_fetch();
    t_external_data_space();
    t_reset();
    final_report();
  end
endmodule

`default_nettype wire
